// [shared/mta_pkg.sv]
// Constants for the station-address table command engine.
// Assumes a 32-bit APB register bus; one aligned word per register.
package mta_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_KEYH = 8'h04;
	localparam logic [7:0] OFS_KEYL = 8'h08;
	localparam logic [7:0] OFS_ATTR = 8'h0C;
	localparam logic [7:0] OFS_STICKY = 8'h10;
	localparam logic [7:0] OFS_SCANCFG = 8'h14;
	localparam logic [7:0] OFS_LASTROW = 8'h18;
	localparam logic [7:0] OFS_SCANCNT = 8'h1C;
	localparam logic [7:0] OFS_POS = 8'h20;
	localparam logic [7:0] OFS_IRQ = 8'h24;
	localparam logic [7:0] OFS_FIDBASE = 8'h40;
	// ==========================================
	// Geometry
	localparam int ROW_W = 6;
	localparam int COL_W = 2;
	localparam int FID_W = 13;
	localparam int ATTR_W = 32;
	localparam int NUM_XFID = 16;
	// ==========================================
	// Control field positions
	localparam int CTRL_TRIG = 0;
	localparam int CTRL_CMD_LO = 1;
	localparam int CTRL_COL_LO = 4;
	localparam int CTRL_ROW_LO = 8;
	localparam int CTRL_TYPE = 16;
	// Attribute fields
	localparam int ATTR_VLD = 0;
	localparam int ATTR_PIN = 1;
	localparam int ATTR_AGE_LO = 2;
	localparam int ATTR_ADDR_LO = 8;
	localparam int ATTR_ATYPE_LO = 20;
	// Sticky flag positions
	localparam int ST_REFRESH = 0;
	localparam int ST_INSERT = 1;
	localparam int ST_REPLACE = 2;
	localparam int ST_REPL_FAIL = 3;
	localparam int ST_LRN_FAIL = 4;
	localparam int ST_MOVED = 5;
	localparam int ST_FORGET = 6;
	localparam int ST_FORGET_FAIL = 7;
	localparam int ST_SEARCH = 8;
	localparam int ST_SEARCH_FAIL = 9;
	localparam int ST_RD_DIRECT = 10;
	localparam int ST_WR_DIRECT = 11;
	localparam int ST_SCAN = 12;
	localparam int ST_W = 13;
	// ==========================================
	// Commands
	typedef enum logic [2:0] {
		CMD_LEARN = 3'h0,
		CMD_FORGET = 3'h1,
		CMD_SEARCH = 3'h2,
		CMD_RDIR = 3'h3,
		CMD_WDIR = 3'h4,
		CMD_SCAN = 3'h5,
		CMD_NOP6 = 3'h6,
		CMD_NOP7 = 3'h7
	} mta_cmd_t;
	// Destination type codes
	localparam logic [2:0] ATYPE_UNICAST = 3'h0;
	localparam logic [2:0] ATYPE_CPU = 3'h1;
	localparam logic [2:0] ATYPE_AGGR = 3'h2;
	localparam logic [2:0] ATYPE_MCAST = 3'h3;
	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : mta_pkg

// [rtl/mta_hash.sv]
// Row hash over station address and filter id.
// Pure combinational fold; same clock domain as the caller.
`timescale 1ns/1ns
module mta_hash #(
	parameter int ROW_W = 6
) (
	// Key
	input wire logic [47:0] mac,
	input wire logic [12:0] fid,
	// Row
	output logic [ROW_W-1:0] row
);
	logic [63:0] key;
	always_comb
	begin
		key = {3'h0, fid, mac};
		row = '0;
		for (int i = 0; i < 64; i++)
		begin
			row[i % ROW_W] = row[i % ROW_W] ^ key[i];
		end
	end
endmodule : mta_hash

// [rtl/mta_engine.sv]
// Host command engine for the hashed station-address table.
// Assumes an APB master on mclk; automatic learning and age scan live elsewhere.
`timescale 1ns/1ns
module mta_engine #(
	parameter int ROW_W = mta_pkg::ROW_W,
	parameter int COL_W = mta_pkg::COL_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Access complete interrupt
	output logic access_done_irq,
	// Entry changes from the learning and aging engines
	input wire logic ext_wr,
	input wire logic [ROW_W+COL_W-1:0] ext_idx,
	input wire logic [31:0] ext_attr,
	// Busy indication
	output logic busy
);
	localparam int NE = 1 << (ROW_W + COL_W);
	localparam int NC = 1 << COL_W;
	localparam int IW = ROW_W + COL_W;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_WALK = 2'b01,
		S_DONE = 2'b10
	} mta_state_t;

	// ==========================================
	// Table storage
	logic [47:0] t_mac [NE];
	logic [12:0] t_fid [NE];
	logic [31:0] t_attr [NE];

	// ==========================================
	// Registers
	logic access_trigger_q;
	logic [2:0] cmd_q;
	logic [COL_W-1:0] dcol_q;
	logic [ROW_W-1:0] drow_q;
	logic dtype_q;
	logic [31:0] staging_key_high_q;
	logic [31:0] staging_key_low_q;
	logic [31:0] staging_entry_attrs_q;
	logic [mta_pkg::ST_W-1:0] sticky_q;
	logic xfid_ena_q;
	logic [ROW_W-1:0] last_row_q;
	logic [ROW_W-1:0] scan_progress_status_q;
	logic [IW-1:0] pos_q;
	logic irq_ena_q;
	logic [12:0] xfid_q [mta_pkg::NUM_XFID];
	mta_state_t state_q;
	logic [COL_W:0] col_q;
	logic [ROW_W-1:0] srow_q;
	logic hit_q;
	logic [IW-1:0] hit_idx_q;
	logic free_q;
	logic [IW-1:0] free_idx_q;
	logic [mta_pkg::ST_W-1:0] ev_set;

	logic wr_acc;
	assign wr_acc = psel && penable && pwrite;

	logic [47:0] key_mac;
	logic [12:0] key_fid;
	assign key_mac = {staging_key_high_q[15:0], staging_key_low_q};
	assign key_fid = staging_key_high_q[28:16];
	logic [ROW_W-1:0] hrow;
	mta_hash #(
		.ROW_W(ROW_W)
	) u_hash (
		.mac(key_mac),
		.fid(key_fid),
		.row(hrow)
	);

	// ==========================================
	// Current probe
	logic [IW-1:0] pidx;
	logic [IW-1:0] didx;
	logic p_vld;
	logic p_match;
	logic s_match;
	assign pidx = {(state_q == S_WALK && cmd_q == mta_pkg::CMD_SCAN) ? srow_q : hrow, col_q[COL_W-1:0]};
	assign didx = {drow_q, dcol_q};
	assign p_vld = t_attr[pidx][mta_pkg::ATTR_VLD];
	assign p_match = p_vld && t_mac[pidx] == key_mac && t_fid[pidx] == key_fid;
	always_comb
	begin
		s_match = p_vld && t_fid[pidx] == key_fid;
		if (xfid_ena_q)
		begin
			for (int i = 0; i < mta_pkg::NUM_XFID; i++)
			begin
				if (p_vld && t_fid[pidx] == xfid_q[i])
				begin
					s_match = 1'b1;
				end
			end
		end
	end

	// ==========================================
	// Command sequencer
	// operation chosen by command code
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_q <= S_IDLE;
			col_q <= '0;
			srow_q <= '0;
			hit_q <= 1'b0;
			hit_idx_q <= '0;
			free_q <= 1'b0;
			free_idx_q <= '0;
		end
		else
		begin
			unique case (state_q)
				S_IDLE:
				begin
					col_q <= '0;
					hit_q <= 1'b0;
					free_q <= 1'b0;
					srow_q <= drow_q;
					if (access_trigger_q)
					begin
						if (cmd_q == mta_pkg::CMD_RDIR || cmd_q == mta_pkg::CMD_WDIR || cmd_q > mta_pkg::CMD_SCAN)
						begin
							state_q <= S_DONE;
						end
						else
						begin
							state_q <= S_WALK;
						end
					end
				end
				S_WALK:
				begin
					// probe each column of the row
					if (cmd_q == mta_pkg::CMD_SCAN ? s_match : p_match)
					begin
						hit_q <= 1'b1;
						hit_idx_q <= pidx;
						state_q <= S_DONE;
					end
					else
					begin
						if (!p_vld && !free_q)
						begin
							free_q <= 1'b1;
							free_idx_q <= pidx;
						end
						if (col_q[COL_W-1:0] == COL_W'(NC - 1))
						begin
							col_q <= '0;
							if (cmd_q != mta_pkg::CMD_SCAN || srow_q == last_row_q)
							begin
								state_q <= S_DONE;
							end
							else
							begin
								srow_q <= srow_q + 1'b1;
							end
						end
						else
						begin
							col_q <= col_q + 1'b1;
						end
					end
				end
				S_DONE:
				begin
					state_q <= S_IDLE;
				end
				default:
				begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Table writes
	always_ff @(posedge mclk)
	begin
		if (state_q == S_DONE)
		begin
			unique case (cmd_q)
				mta_pkg::CMD_LEARN:
				begin
					if (hit_q)
					begin
						t_attr[hit_idx_q] <= staging_entry_attrs_q;
					end
					else if (free_q)
					begin
						t_mac[free_idx_q] <= key_mac;
						t_fid[free_idx_q] <= key_fid;
						t_attr[free_idx_q] <= staging_entry_attrs_q;
					end
				end
				mta_pkg::CMD_FORGET:
				begin
					if (hit_q)
					begin
						t_attr[hit_idx_q] <= '0;
					end
				end
				mta_pkg::CMD_WDIR:
				begin
					t_mac[didx] <= key_mac;
					t_fid[didx] <= key_fid;
					t_attr[didx] <= staging_entry_attrs_q;
				end
				default:
				begin
				end
			endcase
		end
		// pinned entries keep all but age
		else if (ext_wr)
		begin
			if (t_attr[ext_idx][mta_pkg::ATTR_PIN])
			begin
				t_attr[ext_idx][mta_pkg::ATTR_AGE_LO +: 2] <= ext_attr[mta_pkg::ATTR_AGE_LO +: 2];
			end
			else
			begin
				t_attr[ext_idx] <= ext_attr;
			end
		end
	end

	// ==========================================
	// Outcome events
	always_comb
	begin
		ev_set = '0;
		if (state_q == S_DONE)
		begin
			unique case (cmd_q)
				mta_pkg::CMD_LEARN:
				begin
					if (hit_q)
					begin
						ev_set[mta_pkg::ST_REFRESH] = 1'b1;
						// address judged with its type code
						ev_set[mta_pkg::ST_MOVED] = t_attr[hit_idx_q][mta_pkg::ATTR_ADDR_LO +: 15]
							!= staging_entry_attrs_q[mta_pkg::ATTR_ADDR_LO +: 15];
					end
					else if (free_q)
					begin
						ev_set[mta_pkg::ST_INSERT] = 1'b1;
					end
					else
					begin
						ev_set[mta_pkg::ST_REPL_FAIL] = 1'b1;
						ev_set[mta_pkg::ST_LRN_FAIL] = 1'b1;
					end
				end
				mta_pkg::CMD_FORGET:
				begin
					ev_set[hit_q ? mta_pkg::ST_FORGET : mta_pkg::ST_FORGET_FAIL] = 1'b1;
				end
				mta_pkg::CMD_SEARCH:
				begin
					ev_set[hit_q ? mta_pkg::ST_SEARCH : mta_pkg::ST_SEARCH_FAIL] = 1'b1;
				end
				mta_pkg::CMD_RDIR:
				begin
					ev_set[mta_pkg::ST_RD_DIRECT] = 1'b1;
				end
				mta_pkg::CMD_WDIR:
				begin
					ev_set[mta_pkg::ST_WR_DIRECT] = 1'b1;
				end
				mta_pkg::CMD_SCAN:
				begin
					ev_set[mta_pkg::ST_SCAN] = hit_q;
				end
				default:
				begin
				end
			endcase
		end
	end

	// ==========================================
	// Control register and trigger
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			access_trigger_q <= 1'b0;
			cmd_q <= 3'h0;
			dcol_q <= '0;
			drow_q <= '0;
			dtype_q <= 1'b0;
		end
		else
		begin
			if (wr_acc && paddr == mta_pkg::OFS_CTRL && !access_trigger_q)
			begin
				cmd_q <= pwdata[mta_pkg::CTRL_CMD_LO +: 3];
				dcol_q <= pwdata[mta_pkg::CTRL_COL_LO +: COL_W];
				drow_q <= pwdata[mta_pkg::CTRL_ROW_LO +: ROW_W];
				dtype_q <= pwdata[mta_pkg::CTRL_TYPE];
				access_trigger_q <= pwdata[mta_pkg::CTRL_TRIG];
			end
			else if (state_q == S_DONE)
			begin
				access_trigger_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// Staging registers
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			staging_key_high_q <= mta_pkg::RST_ZERO;
			staging_key_low_q <= mta_pkg::RST_ZERO;
			staging_entry_attrs_q <= mta_pkg::RST_ZERO;
		end
		else if (state_q == S_DONE)
		begin
			if (cmd_q == mta_pkg::CMD_RDIR)
			begin
				staging_key_high_q <= {3'h0, t_fid[didx], t_mac[didx][47:32]};
				staging_key_low_q <= t_mac[didx][31:0];
				staging_entry_attrs_q <= t_attr[didx];
			end
			else if (cmd_q == mta_pkg::CMD_SEARCH && hit_q)
			begin
				staging_entry_attrs_q <= t_attr[hit_idx_q];
			end
		end
		else if (wr_acc && !access_trigger_q)
		begin
			if (paddr == mta_pkg::OFS_KEYH)
			begin
				staging_key_high_q <= {3'h0, pwdata[28:0]};
			end
			if (paddr == mta_pkg::OFS_KEYL)
			begin
				staging_key_low_q <= pwdata;
			end
			if (paddr == mta_pkg::OFS_ATTR)
			begin
				staging_entry_attrs_q <= pwdata;
			end
		end
	end

	// ==========================================
	// Sticky flags, status and config
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			sticky_q <= '0;
		end
		// write one clears; new events win
		else if (wr_acc && paddr == mta_pkg::OFS_STICKY)
		begin
			sticky_q <= (sticky_q & ~pwdata[mta_pkg::ST_W-1:0]) | ev_set;
		end
		else
		begin
			sticky_q <= sticky_q | ev_set;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pos_q <= '0;
			scan_progress_status_q <= '0;
		end
		else if (state_q == S_DONE)
		begin
			pos_q <= (cmd_q == mta_pkg::CMD_RDIR || cmd_q == mta_pkg::CMD_WDIR) ? didx
				: (hit_q ? hit_idx_q : (free_q ? free_idx_q : pidx));
			scan_progress_status_q <= srow_q;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			xfid_ena_q <= 1'b0;
			last_row_q <= '1;
			irq_ena_q <= 1'b0;
		end
		else if (wr_acc)
		begin
			if (paddr == mta_pkg::OFS_SCANCFG)
			begin
				xfid_ena_q <= pwdata[0];
			end
			if (paddr == mta_pkg::OFS_LASTROW)
			begin
				last_row_q <= pwdata[ROW_W-1:0];
			end
			if (paddr == mta_pkg::OFS_IRQ)
			begin
				irq_ena_q <= pwdata[0];
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < mta_pkg::NUM_XFID; i++)
		begin
			if (srst)
			begin
				xfid_q[i] <= '0;
			end
			else if (wr_acc && paddr == mta_pkg::OFS_FIDBASE + 8'(4 * i))
			begin
				xfid_q[i] <= pwdata[12:0];
			end
		end
	end

	// ==========================================
	// Read data and outputs
	logic [31:0] rd_d;
	logic rd_err;
	always_comb
	begin
		rd_d = '0;
		rd_err = 1'b0;
		unique case (paddr)
			mta_pkg::OFS_CTRL: rd_d = {15'h0000, dtype_q, 2'h0, drow_q, 2'h0, dcol_q, cmd_q, access_trigger_q};
			mta_pkg::OFS_KEYH: rd_d = staging_key_high_q;
			mta_pkg::OFS_KEYL: rd_d = staging_key_low_q;
			mta_pkg::OFS_ATTR: rd_d = staging_entry_attrs_q;
			mta_pkg::OFS_STICKY: rd_d = {19'h00000, sticky_q};
			mta_pkg::OFS_SCANCFG: rd_d = {31'h00000000, xfid_ena_q};
			mta_pkg::OFS_LASTROW: rd_d = {26'h0000000, last_row_q};
			mta_pkg::OFS_SCANCNT: rd_d = {26'h0000000, scan_progress_status_q};
			mta_pkg::OFS_POS: rd_d = {24'h000000, pos_q};
			mta_pkg::OFS_IRQ: rd_d = {31'h00000000, irq_ena_q};
			default:
			begin
				if (paddr >= mta_pkg::OFS_FIDBASE && paddr < mta_pkg::OFS_FIDBASE + 8'h40 && paddr[1:0] == 2'h0)
				begin
					rd_d = {19'h00000, xfid_q[paddr[5:2]]};
				end
				else
				begin
					rd_err = 1'b1;
				end
			end
		endcase
	end

	// Answer in the first access cycle; pready is a registered setup-phase echo
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			access_done_irq <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && rd_err;
			prdata <= (psel && !penable && !pwrite) ? rd_d : 32'h0000_0000;
			access_done_irq <= irq_ena_q && state_q == S_DONE;
			busy <= access_trigger_q;
		end
	end
endmodule : mta_engine

// [test/mta_engine_chk.sv]
// ==========================================
// Port checker for the table command engine.
// Sees only engine ports; bound to every mta_engine instance.
`timescale 1ns/1ns
module mta_engine_chk #(
	parameter int ROW_W = 6,
	parameter int COL_W = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Status
	input wire logic access_done_irq,
	input wire logic ext_wr,
	input wire logic [ROW_W+COL_W-1:0] ext_idx,
	input wire logic [31:0] ext_attr,
	input wire logic busy
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	// ==========================================
	// Sequences
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_trig_wr;
		psel && !penable && pwrite && paddr == mta_pkg::OFS_CTRL && pwdata[0];
	endsequence
	// ==========================================
	// Assertions
	AST_READY_ONE:
		assert property (s_setup |=> pready) else $error("no ready after setup");
	AST_READY_CAUSE:
		assert property (!(psel && !penable) |=> !pready) else $error("ready without setup");
	AST_ERR_READY:
		assert property (pslverr |-> pready) else $error("error without ready");
	AST_ERR_HIGH:
		assert property (s_setup ##0 paddr[7] |=> pslverr && pready) else $error("unmapped not refused");
	AST_ERR_CTRL:
		assert property (s_setup ##0 (paddr == mta_pkg::OFS_CTRL) |=> !pslverr) else $error("control refused");
	AST_START:
		assert property (s_trig_wr ##0 !busy |-> ##[1:3] busy) else $error("trigger did not start");
	AST_BUSY_END:
		assert property ($rose(busy) |-> ##[1:700] !busy) else $error("command never finished");
	AST_IRQ_PULSE:
		assert property (access_done_irq |=> !access_done_irq) else $error("irq longer than a cycle");
	AST_IRQ_QUIET:
		assert property (!busy [*3] |-> !access_done_irq) else $error("irq while idle");
endmodule : mta_engine_chk

bind mta_engine mta_engine_chk #(.ROW_W(ROW_W), .COL_W(COL_W)) i_chk (
	.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.access_done_irq(access_done_irq), .ext_wr(ext_wr), .ext_idx(ext_idx), .ext_attr(ext_attr), .busy(busy)
);

// [test/test_mac_table_cpu_access.sv]
// ==========================================
// Self-checking bench for the table command engine.
// Drives APB with xorshift data; learning inputs write entry 0x5A twice, once pinned and once plain.
`timescale 1ns/1ns
module test_mac_table_cpu_access;
	logic mclk, srst, psel, penable, pwrite, pready, pslverr, access_done_irq, ext_wr, busy, lerr;
	logic [7:0] paddr, ext_idx, idx;
	logic [31:0] pwdata, prdata, ext_attr, rd, seed, k_hi, k_lo, att, upd;
	logic [31:0] tab [logic [63:0]];
	int err_total, samples_checked, irq_seen, cmds;

	mta_engine i_dut (
		.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.access_done_irq(access_done_irq), .ext_wr(ext_wr), .ext_idx(ext_idx), .ext_attr(ext_attr), .busy(busy)
	);

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk)
		if (access_done_irq === 1'b1)
			irq_seen++;

	// ==========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One transfer; an idle edge follows so psel is never driven twice at once
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do
		begin
			@(posedge mclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		lerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic stage(input logic [31:0] h, input logic [31:0] l, input logic [31:0] a);
		apb(1'b1, mta_pkg::OFS_KEYH, h);
		apb(1'b1, mta_pkg::OFS_KEYL, l);
		apb(1'b1, mta_pkg::OFS_ATTR, a);
	endtask : stage

	task automatic cmd(input logic [2:0] c, input logic [7:0] i, input logic poke);
		int n;
		apb(1'b1, mta_pkg::OFS_CTRL, {18'h0, i[7:2], 2'h0, i[1:0], c, 1'b1});
		cmds++;
		if (poke)
			apb(1'b1, mta_pkg::OFS_KEYL, ~k_lo);
		n = 0;
		do
		begin
			apb(1'b0, mta_pkg::OFS_CTRL, 32'h0);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 300);
		chk(rd & 32'h1, 32'h0);
		chk({31'h0, busy}, 32'h0);
	endtask : cmd

	// Read flags, then clear them all
	task automatic stick(input logic [31:0] e);
		apb(1'b0, mta_pkg::OFS_STICKY, 32'h0);
		chk(rd, e);
		apb(1'b1, mta_pkg::OFS_STICKY, 32'h1FFF);
	endtask : stick

	// Model of hashed commands: keys learned so far and their attributes
	task automatic hashed(input logic [2:0] c, input logic poke);
		logic [63:0] key;
		logic [31:0] e;
		logic hit;
		key = {k_hi, k_lo};
		hit = tab.exists(key);
		stage(k_hi, k_lo, (c == mta_pkg::CMD_SEARCH) ? 32'h0 : att);
		cmd(c, 8'h00, poke);
		if (c == mta_pkg::CMD_LEARN)
			e = hit ? ((32'h1 << mta_pkg::ST_REFRESH) | ((tab[key][19:8] != att[19:8]) << mta_pkg::ST_MOVED))
				: (32'h1 << mta_pkg::ST_INSERT);
		else if (c == mta_pkg::CMD_FORGET)
			e = 32'h1 << (hit ? mta_pkg::ST_FORGET : mta_pkg::ST_FORGET_FAIL);
		else
			e = 32'h1 << (hit ? mta_pkg::ST_SEARCH : mta_pkg::ST_SEARCH_FAIL);
		stick(e);
		if (c == mta_pkg::CMD_SEARCH && hit)
		begin
			apb(1'b0, mta_pkg::OFS_ATTR, 32'h0);
			chk(rd, tab[key]);
		end
		if (c == mta_pkg::CMD_LEARN)
			tab[key] = att;
		if (c == mta_pkg::CMD_FORGET)
			tab.delete(key);
	endtask : hashed

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	initial
	begin
		repeat (60000) @(posedge mclk);
		err_total++;
		complete_run();
	end

	// ==========================================
	// Main sequence
	initial
	begin
		seed = 32'hC4768651;
		{srst, psel, penable, pwrite, paddr, pwdata, ext_wr, ext_idx, ext_attr} = '0;
		srst = 1'b1;
		{err_total, samples_checked, irq_seen, cmds} = '0;
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		apb(1'b0, mta_pkg::OFS_CTRL, 32'h0);
		chk(rd, mta_pkg::RST_ZERO);
		stick(mta_pkg::RST_ZERO);
		apb(1'b0, mta_pkg::OFS_LASTROW, 32'h0);
		chk(rd & 32'h3F, 32'h3F);
		apb(1'b0, 8'h28, 32'h0);
		chk({31'h0, lerr}, 32'h1);
		apb(1'b0, 8'h84, 32'h0);
		chk({31'h0, lerr}, 32'h1);
		apb(1'b1, mta_pkg::OFS_IRQ, 32'h1);
		// Table memory is not reset, so blank it before hashed commands
		stage(32'h0, 32'h0, 32'h0);
		for (int i = 0; i < 256; i++)
			cmd(mta_pkg::CMD_WDIR, i[7:0], 1'b0);
		stick(32'h1 << mta_pkg::ST_WR_DIRECT);
		for (int i = 0; i < 4; i++)
		begin
			att = rnd();
			idx = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : att[7:0];
			k_hi = rnd() & 32'h1FFF_FFFF;
			k_lo = rnd();
			att = rnd() & 32'h007F_FF0F;
			stage(k_hi, k_lo, att);
			cmd(mta_pkg::CMD_WDIR, idx, 1'b0);
			stage(32'h0, 32'h0, 32'h0);
			cmd(mta_pkg::CMD_RDIR, idx, 1'b0);
			apb(1'b0, mta_pkg::OFS_KEYH, 32'h0);
			chk(rd, k_hi);
			apb(1'b0, mta_pkg::OFS_KEYL, 32'h0);
			chk(rd, k_lo);
			apb(1'b0, mta_pkg::OFS_ATTR, 32'h0);
			chk(rd, att);
			stick((32'h1 << mta_pkg::ST_WR_DIRECT) | (32'h1 << mta_pkg::ST_RD_DIRECT));
		end
		k_hi = rnd() & 32'h1FFF_FFFF;
		k_lo = rnd();
		att = (rnd() & 32'h007F_FF0C) | 32'h1;
		hashed(mta_pkg::CMD_LEARN, 1'b0);
		hashed(mta_pkg::CMD_SEARCH, 1'b0);
		hashed(mta_pkg::CMD_LEARN, 1'b0);
		att = att ^ 32'h0000_0100;
		hashed(mta_pkg::CMD_LEARN, 1'b0);
		hashed(mta_pkg::CMD_FORGET, 1'b0);
		hashed(mta_pkg::CMD_SEARCH, 1'b1);
		apb(1'b0, mta_pkg::OFS_KEYL, 32'h0);
		chk(rd, k_lo);
		hashed(mta_pkg::CMD_FORGET, 1'b0);
		// Outside update of a pinned entry, then of a plain one
		for (int p = 0; p < 2; p++)
		begin
			k_hi = rnd() & 32'h1FFF_FFFF;
			k_lo = rnd();
			att = (rnd() & 32'h007F_FF0D) | ((p == 0) ? 32'h3 : 32'h1);
			upd = rnd() | 32'h1;
			stage(k_hi, k_lo, att);
			cmd(mta_pkg::CMD_WDIR, 8'h5A, 1'b0);
			ext_idx <= 8'h5A;
			ext_attr <= upd;
			ext_wr <= 1'b1;
			@(posedge mclk);
			ext_wr <= 1'b0;
			@(posedge mclk);
			cmd(mta_pkg::CMD_RDIR, 8'h5A, 1'b0);
			apb(1'b0, mta_pkg::OFS_ATTR, 32'h0);
			chk(rd, (p == 0) ? ((att & ~32'hC) | (upd & 32'hC)) : upd);
			stick((32'h1 << mta_pkg::ST_WR_DIRECT) | (32'h1 << mta_pkg::ST_RD_DIRECT));
		end
		// Scan for the entry at 0x5A: cut short by the last row, then found
		apb(1'b1, mta_pkg::OFS_LASTROW, 32'h15);
		stage(k_hi, k_lo, 32'h0);
		cmd(mta_pkg::CMD_SCAN, 8'h00, 1'b0);
		apb(1'b0, mta_pkg::OFS_SCANCNT, 32'h0);
		chk(rd, 32'h15);
		stick(32'h0);
		apb(1'b1, mta_pkg::OFS_LASTROW, 32'h3F);
		cmd(mta_pkg::CMD_SCAN, 8'h00, 1'b0);
		apb(1'b0, mta_pkg::OFS_SCANCNT, 32'h0);
		chk(rd, 32'h16);
		apb(1'b0, mta_pkg::OFS_POS, 32'h0);
		chk(rd, 32'h5A);
		stick(32'h1 << mta_pkg::ST_SCAN);
		// Other fid staged; the extra filter matches only once enabled
		apb(1'b1, mta_pkg::OFS_FIDBASE + 8'h0C, {19'h0, k_hi[28:16]});
		stage(k_hi ^ 32'h0001_0000, k_lo, 32'h0);
		cmd(mta_pkg::CMD_SCAN, 8'h00, 1'b0);
		stick(32'h0);
		apb(1'b1, mta_pkg::OFS_SCANCFG, 32'h1);
		cmd(mta_pkg::CMD_SCAN, 8'h00, 1'b0);
		stick(32'h1 << mta_pkg::ST_SCAN);
		cmd(mta_pkg::CMD_SCAN, 8'h00, 1'b0);
		apb(1'b1, mta_pkg::OFS_STICKY, 32'h1FFF);
		cmd(mta_pkg::CMD_NOP6, 8'h00, 1'b0);
		cmd(mta_pkg::CMD_NOP7, 8'h00, 1'b0);
		stick(32'h0);
		chk(irq_seen, cmds);
		apb(1'b1, mta_pkg::OFS_IRQ, 32'h0);
		cmd(mta_pkg::CMD_NOP6, 8'h00, 1'b0);
		chk(irq_seen, cmds - 1);
		complete_run();
	end
endmodule : test_mac_table_cpu_access
